// ===== src/eipc_pkg.sv
/*
 * Constants, register map and source table of the external request and
 * priority controller. Assumes a single 10 MHz clock and an AHB-Lite bus.
 */
// Summary of operation
// RL1: chip reset and hardware standby clear priority B, flags, enable and sense registers.
// RL2: priority B bit 7 puts timer channel 3 requests at level 1.
// RL3: priority B bit 6 puts timer channel 4 requests at level 1.
// RL4: priority B bit 3 sets the level of all serial port requests.
// RL5: priority B bit 1 sets the level of converter requests.
// RL6: priority B bits 5, 4, 2, 0 are plain storage without effect.
// RL7: priority A bit 0 sets timer channel 2 level; resets to zero.
// RL8: flag register bits 7 to 5 always read zero.
// RL9: flag sets while pin low (level) or on falling pin edge (edge).
// RL10: software clears a flag only by writing 0 after reading 1; writing 1 never sets.
// RL11: level line flag clears on its exception handling when pin is high.
// RL12: edge line flag clears automatically on its exception handling.
// RL13: enable bits 4 to 0 gate external lines 4 to 0; all off after reset.
// RL14: enable bits 7 to 5 are plain storage.
// RL15: sense bits 4 to 0 choose level (0) or falling edge (1) per line.
// RL16: sense bits 7 to 5 are plain storage.
// RL17: nonmaskable input wins always, regardless of masks, with vector 7.
// RL18: nonmaskable edge bit picks rising or falling edge of its pin.
// RL19: external lines 0 to 4 carry vectors 12 to 16.
// RL20: line detection works regardless of the pin's direction setting.
// RL21: nonmaskable input and lines 0 to 2 wake from software standby; 3, 4 not.
// RL22: twenty-one internal requests enter, leveled by the two priority registers.
// RL23: nonmaskable edge bit 0 means falling edge and resets to 0.
// RL24: priority A bits 7 to 4 level line 0, line 1, lines 2-3, line 4.
// RL25: at equal level the smaller vector number wins.
// RL26: present highest-level pending enabled request with its vector.
package eipc_pkg;
	localparam int EIPC_NSRC = 26;
	localparam int EIPC_NINT = 21;
	localparam logic [7:0] EIPC_OFF_PRI_A = 8'h00;
	localparam logic [7:0] EIPC_OFF_PRI_B = 8'h04;
	localparam logic [7:0] EIPC_OFF_SENSE = 8'h08;
	localparam logic [7:0] EIPC_OFF_ENABLE = 8'h0C;
	localparam logic [7:0] EIPC_OFF_FLAGS = 8'h10;
	localparam logic [7:0] EIPC_OFF_SYSCTL = 8'h14;
	localparam logic [7:0] EIPC_OFF_STATUS = 8'h18;
	localparam logic [7:0] EIPC_RST_BYTE = 8'h00;
	localparam logic [7:0] EIPC_RST_SYSCTL = 8'h0B;
	localparam int EIPC_NMI_EDGE_BIT = 2;
	localparam logic [7:0] EIPC_VEC_NMI = 8'h07;
	localparam logic [7:0] EIPC_VEC_LINE0 = 8'h0C;
	localparam logic [1:0] EIPC_HTRANS_NONSEQ = 2'h2;
	// converter vector is outside the visible table, so it is a plain default
	localparam logic [7:0] EIPC_VEC_ADC = 8'h3C;
	// index 0..4 external lines, 5..25 internal requests in input order
	localparam logic [7:0] EIPC_SRC_VEC [EIPC_NSRC] = '{
		8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h14,
		8'h18, 8'h19, 8'h1A, 8'h1C, 8'h1D, 8'h1E,
		8'h20, 8'h21, 8'h22, 8'h24, 8'h25, 8'h26,
		8'h28, 8'h29, 8'h2A, 8'h34, 8'h35, 8'h36, 8'h37, EIPC_VEC_ADC};
	typedef enum logic [1:0] {
		EIPC_BUS_IDLE = 2'b00,
		EIPC_BUS_DATA = 2'b01
	} eipc_bus_t;
endpackage

// ===== src/eipc_ctrl.sv
/*
 * External request and priority controller: pin sensing, flags, enables,
 * two-level priority arbitration and an AHB-Lite register slave.
 * Assumes the core pulses cpu_ack_in with the vector it starts handling.
 */
`timescale 1ns/10ps
module eipc_ctrl
(
	input wire logic core_clk_in,
	input wire logic srst_in,
	input wire logic hw_standby_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	input wire logic nmi_pin_in,
	input wire logic [4:0] line_n_in,
	input wire logic [eipc_pkg::EIPC_NINT-1:0] int_req_in,
	input wire logic cpu_ack_in,
	input wire logic [7:0] cpu_ack_vec_in,
	output logic irq_req_out,
	output logic irq_nmi_out,
	output logic irq_level_out,
	output logic [7:0] irq_vec_out,
	output logic wake_out
);
	import eipc_pkg::*;

	logic [7:0] priority_select_a;
	logic [7:0] priority_select_b;
	logic [7:0] ext_sense_select;
	logic [7:0] ext_request_enable;
	logic [4:0] line_pending_flag;
	logic [7:0] system_control_reg;
	logic [4:0] seen_one;
	logic nmi_pending;
	logic [4:0] line_s1, line_s2, line_prev;
	logic nmi_s1, nmi_s2, nmi_prev;
	logic reg_clr;
	eipc_bus_t bus_state;
	logic [7:0] wr_addr;
	logic wr_pend;
	logic addr_ok;
	logic [4:0] line_fall;
	logic nmi_edge;
	logic [4:0] flag_wr_clr;
	logic [4:0] ack_clr;
	logic [4:0] line_enable_bit;
	logic [EIPC_NSRC-1:0] src_req;
	logic best_valid;
	logic best_level;
	logic [7:0] best_vec;
	logic [7:0] rd_byte;

	assign reg_clr = srst_in | hw_standby_in;
	assign line_enable_bit = ext_request_enable[4:0];

	// priority level of each source from the two priority registers
	function automatic logic src_level(input int idx, input logic [7:0] pa,
		input logic [7:0] pb);
		logic lv;
		lv = 1'b0;
		case (idx)
			0: lv = pa[7]; // [RL24]
			1: lv = pa[6];
			2, 3: lv = pa[5];
			4: lv = pa[4];
			5: lv = pa[3];
			6, 7, 8: lv = pa[2];
			9, 10, 11: lv = pa[1];
			12, 13, 14: lv = pa[0]; // [RL7]
			15, 16, 17: lv = pb[7]; // [RL2]
			18, 19, 20: lv = pb[6]; // [RL3]
			21, 22, 23, 24: lv = pb[3]; // [RL4]
			25: lv = pb[1]; // [RL5]
			default: lv = 1'b0;
		endcase
		return lv;
	endfunction

	// pins come from outside the clock domain; the first stage feeds only the second
	// reset loads the idle pin levels, so no false edge follows reset
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			line_s1 <= 5'h1F;
			line_s2 <= 5'h1F;
			line_prev <= 5'h1F;
			nmi_s1 <= 1'b0;
			nmi_s2 <= 1'b0;
			nmi_prev <= 1'b0;
		end else begin
			line_s1 <= line_n_in; // [RL20]
			line_s2 <= line_s1;
			line_prev <= line_s2;
			nmi_s1 <= nmi_pin_in;
			nmi_s2 <= nmi_s1;
			nmi_prev <= nmi_s2;
		end
	end

	assign line_fall = line_prev & ~line_s2;
	// [RL18] [RL23]
	assign nmi_edge = system_control_reg[EIPC_NMI_EDGE_BIT] ? (nmi_s2 & ~nmi_prev) :
		(~nmi_s2 & nmi_prev);

	// bus slave: zero wait states, address phase captured, write done in data phase
	// hsize is ignored: each register is one aligned word with its data in bits 7:0, status in bits 9:0
	assign addr_ok = (haddr_in[7:0] == EIPC_OFF_PRI_A) || (haddr_in[7:0] == EIPC_OFF_PRI_B) ||
		(haddr_in[7:0] == EIPC_OFF_SENSE) || (haddr_in[7:0] == EIPC_OFF_ENABLE) ||
		(haddr_in[7:0] == EIPC_OFF_FLAGS) || (haddr_in[7:0] == EIPC_OFF_SYSCTL) ||
		(haddr_in[7:0] == EIPC_OFF_STATUS);

	always_comb begin
		case (haddr_in[7:0])
			EIPC_OFF_PRI_A: rd_byte = priority_select_a;
			EIPC_OFF_PRI_B: rd_byte = priority_select_b;
			EIPC_OFF_SENSE: rd_byte = ext_sense_select;
			EIPC_OFF_ENABLE: rd_byte = ext_request_enable;
			EIPC_OFF_FLAGS: rd_byte = {3'h0, line_pending_flag}; // [RL8]
			EIPC_OFF_SYSCTL: rd_byte = system_control_reg;
			EIPC_OFF_STATUS: rd_byte = irq_vec_out;
			default: rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			bus_state <= EIPC_BUS_IDLE;
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			hrdata_out <= 32'h00000000;
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
		end else begin
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
			if (hready_in && hsel_in && htrans_in == EIPC_HTRANS_NONSEQ) begin
				bus_state <= EIPC_BUS_DATA;
				wr_pend <= hwrite_in && addr_ok;
				wr_addr <= haddr_in[7:0];
				hrdata_out <= (hwrite_in || !addr_ok) ? 32'h00000000 :
					((haddr_in[7:0] == EIPC_OFF_STATUS) ?
					{22'h0, irq_req_out, irq_level_out, irq_vec_out} :
					{24'h000000, rd_byte});
			end else if (hready_in) begin
				bus_state <= EIPC_BUS_IDLE;
				wr_pend <= 1'b0;
			end
		end
	end

	// configuration registers
	always_ff @(posedge core_clk_in) begin
		if (reg_clr) begin
			priority_select_a <= EIPC_RST_BYTE; // [RL1] [RL7]
			priority_select_b <= EIPC_RST_BYTE;
			ext_sense_select <= EIPC_RST_BYTE;
			ext_request_enable <= EIPC_RST_BYTE; // [RL13]
			system_control_reg <= EIPC_RST_SYSCTL; // [RL23]
		end else if (bus_state == EIPC_BUS_DATA && wr_pend) begin
			case (wr_addr)
				EIPC_OFF_PRI_A: priority_select_a <= hwdata_in[7:0];
				EIPC_OFF_PRI_B: priority_select_b <= hwdata_in[7:0]; // [RL6]
				EIPC_OFF_SENSE: ext_sense_select <= hwdata_in[7:0]; // [RL16]
				EIPC_OFF_ENABLE: ext_request_enable <= hwdata_in[7:0]; // [RL14]
				EIPC_OFF_SYSCTL: system_control_reg <= hwdata_in[7:0];
				default: priority_select_a <= priority_select_a;
			endcase
		end
	end

	// a flag may be cleared by software only where it was seen as one
	always_ff @(posedge core_clk_in) begin
		if (reg_clr) begin
			seen_one <= 5'h00;
		end else if (hready_in && hsel_in && htrans_in == EIPC_HTRANS_NONSEQ &&
			!hwrite_in && haddr_in[7:0] == EIPC_OFF_FLAGS) begin
			seen_one <= seen_one | line_pending_flag; // [RL10]
		end else begin
			seen_one <= seen_one & ~flag_wr_clr;
		end
	end

	assign flag_wr_clr = (bus_state == EIPC_BUS_DATA && wr_pend && wr_addr == EIPC_OFF_FLAGS) ?
		(seen_one & ~hwdata_in[4:0]) : 5'h00; // [RL10]

	always_comb begin
		for (int n = 0; n < 5; n++) begin
			ack_clr[n] = cpu_ack_in && cpu_ack_vec_in == EIPC_SRC_VEC[n] &&
				(ext_sense_select[n] || line_s2[n]); // [RL11] [RL12]
		end
	end

	// set wins over any clear in the same cycle; writing one never sets
	always_ff @(posedge core_clk_in) begin
		if (reg_clr) begin
			line_pending_flag <= 5'h00;
		end else begin
			for (int n = 0; n < 5; n++) begin
				if (ext_sense_select[n] ? line_fall[n] : !line_s2[n]) begin
					line_pending_flag[n] <= 1'b1; // [RL9] [RL15]
				end else if (flag_wr_clr[n] || ack_clr[n]) begin
					line_pending_flag[n] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (reg_clr) begin
			nmi_pending <= 1'b0;
		end else if (nmi_edge) begin
			nmi_pending <= 1'b1; // [RL18]
		end else if (cpu_ack_in && cpu_ack_vec_in == EIPC_VEC_NMI) begin
			nmi_pending <= 1'b0;
		end
	end

	// internal modules gate their own requests, so they enter unmasked
	assign src_req = {int_req_in, line_pending_flag & line_enable_bit}; // [RL13] [RL22]

	// two passes: low level first, then high, which overrides; lowest index holds lowest vector
	always_comb begin
		best_valid = 1'b0;
		best_level = 1'b0;
		best_vec = 8'h00;
		for (int i = EIPC_NSRC - 1; i >= 0; i--) begin
			if (src_req[i] && !src_level(i, priority_select_a, priority_select_b)) begin
				best_valid = 1'b1;
				best_vec = EIPC_SRC_VEC[i]; // [RL25]
			end
		end
		for (int i = EIPC_NSRC - 1; i >= 0; i--) begin
			if (src_req[i] && src_level(i, priority_select_a, priority_select_b)) begin
				best_valid = 1'b1;
				best_level = 1'b1;
				best_vec = EIPC_SRC_VEC[i]; // [RL26]
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (reg_clr) begin
			irq_req_out <= 1'b0;
			irq_nmi_out <= 1'b0;
			irq_level_out <= 1'b0;
			irq_vec_out <= 8'h00;
			wake_out <= 1'b0;
		end else begin
			irq_req_out <= nmi_pending | best_valid;
			irq_nmi_out <= nmi_pending; // [RL17]
			irq_level_out <= nmi_pending | best_level;
			irq_vec_out <= nmi_pending ? EIPC_VEC_NMI : best_vec; // [RL17] [RL19]
			// lines 3 and 4 cannot leave software standby
			wake_out <= nmi_pending | (|(line_pending_flag[2:0] & line_enable_bit[2:0])); // [RL21]
		end
	end

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (srst_in);

	property p_regs_clear;
		hw_standby_in |=> (priority_select_b == 8'h00 && ext_request_enable == 8'h00 &&
			ext_sense_select == 8'h00 && line_pending_flag == 5'h00);
	endproperty
	a_regs_clear: assert property (p_regs_clear) else $error("standby left registers set"); // [RL1]

	property p_level_set;
		(!hw_standby_in && !ext_sense_select[0] && !line_s2[0]) |=> line_pending_flag[0];
	endproperty
	a_level_set: assert property (p_level_set) else $error("level line flag not set"); // [RL9]

	property p_edge_set;
		(!hw_standby_in && ext_sense_select[1] && line_fall[1]) |=> line_pending_flag[1];
	endproperty
	a_edge_set: assert property (p_edge_set) else $error("edge line flag not set"); // [RL15]

	property p_clear_cause;
		(!hw_standby_in && line_pending_flag[2] && !flag_wr_clr[2] && !ack_clr[2])
			|=> line_pending_flag[2];
	endproperty
	a_clear_cause: assert property (p_clear_cause) else $error("flag cleared without cause"); // [RL10]

	property p_edge_ack;
		(!hw_standby_in && ext_sense_select[0] && !line_fall[0] && cpu_ack_in &&
			cpu_ack_vec_in == EIPC_VEC_LINE0) |=> !line_pending_flag[0];
	endproperty
	a_edge_ack: assert property (p_edge_ack) else $error("edge flag kept after handling"); // [RL12]

	property p_nmi_first;
		(nmi_pending && !hw_standby_in) |=> (irq_req_out && irq_nmi_out && irq_vec_out == 8'h07);
	endproperty
	a_nmi_first: assert property (p_nmi_first) else $error("nonmaskable request not presented"); // [RL17]

	property p_nmi_rise;
		(!hw_standby_in && system_control_reg[EIPC_NMI_EDGE_BIT] && nmi_s2 && !nmi_prev)
			|=> nmi_pending ##1 irq_vec_out == 8'h07;
	endproperty
	a_nmi_rise: assert property (p_nmi_rise) else $error("rising edge missed"); // [RL18]

	property p_timer3_level;
		(!hw_standby_in && !nmi_pending && src_req[15] && priority_select_b[7])
			|=> (irq_level_out && irq_vec_out <= 8'h24);
	endproperty
	a_timer3_level: assert property (p_timer3_level) else $error("timer 3 level wrong"); // [RL2]

	property p_no_wake_hi;
		(!hw_standby_in && !nmi_pending && line_pending_flag[2:0] == 3'h0) |=> !wake_out;
	endproperty
	a_no_wake_hi: assert property (p_no_wake_hi) else $error("lines 3-4 woke the device"); // [RL21]

	property p_flag_top_zero;
		(hready_in && hsel_in && htrans_in == EIPC_HTRANS_NONSEQ && !hwrite_in &&
			haddr_in[7:0] == EIPC_OFF_FLAGS) |=> hrdata_out[7:5] == 3'h0;
	endproperty
	a_flag_top_zero: assert property (p_flag_top_zero) else $error("flag top bits not zero"); // [RL8]

	property p_level_ack;
		(!hw_standby_in && !ext_sense_select[0] && line_s2[0] && cpu_ack_in &&
			cpu_ack_vec_in == EIPC_VEC_LINE0) |=> !line_pending_flag[0];
	endproperty
	a_level_ack: assert property (p_level_ack) else $error("level flag kept"); // [RL11]

	property p_line4_level;
		(!hw_standby_in && !nmi_pending && src_req[4] && priority_select_a[4])
			|=> (irq_level_out && irq_vec_out <= 8'h10);
	endproperty
	a_line4_level: assert property (p_line4_level) else $error("line 4 level wrong"); // [RL24]

	property p_nmi_ack;
		(!hw_standby_in && !nmi_edge && cpu_ack_in && cpu_ack_vec_in == EIPC_VEC_NMI)
			|=> !nmi_pending;
	endproperty
	a_nmi_ack: assert property (p_nmi_ack) else $error("nonmaskable request kept"); // [RL17]

	c_nmi: cover property (nmi_pending ##1 irq_nmi_out);
	c_sw_clear: cover property (line_pending_flag[0] ##1 flag_wr_clr[0]);
	c_hi_wins: cover property (irq_req_out && irq_level_out && !irq_nmi_out);
	c_wake: cover property (wake_out && !irq_nmi_out);
	c_line_hi: cover property (irq_level_out && irq_vec_out == 8'h10);
endmodule // eipc_ctrl

// ===== tb/eipc_core_model.sv
/*
 * Core-side partner: takes the presented request and pulses an acknowledge
 * carrying its vector after a programmable delay.
 * Assumes registered request outputs and a single shared clock.
 */
`timescale 1ns/10ps
module eipc_core_model (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic en_in,
	input wire logic [3:0] delay_in,
	input wire logic irq_req_in,
	input wire logic [7:0] irq_vec_in,
	output logic ack_out,
	output logic [7:0] ack_vec_out
);
	logic [3:0] wait_cnt;
	logic [1:0] hold_cnt;
	// hold-off after each ack skips the stale arbitration cycle
	always_ff @(posedge clk_in) begin
		ack_out <= 1'b0;
		if (srst_in) begin
			wait_cnt <= 4'h0;
			hold_cnt <= 2'h0;
			ack_vec_out <= 8'h00;
		end else if (hold_cnt != 2'h0) begin
			hold_cnt <= hold_cnt - 2'h1;
		end else if (en_in && irq_req_in) begin
			if (wait_cnt == delay_in) begin
				// no mask level here: whatever is presented is taken
				ack_out <= 1'b1;
				ack_vec_out <= irq_vec_in;
				wait_cnt <= 4'h0;
				hold_cnt <= 2'h3;
			end else begin
				wait_cnt <= wait_cnt + 4'h1;
			end
		end else begin
			wait_cnt <= 4'h0;
		end
	end
endmodule // eipc_core_model

// ===== tb/eipc_ctrl_tb_top.sv
/*
 * Self-checking bench for the request and priority controller.
 * Assumes the AHB-Lite slave is the only one on the bus and the core model
 * acknowledges requests only while enabled.
 */
`timescale 1ns/10ps
module eipc_ctrl_tb_top;
	import eipc_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic stby = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h00000000;
	logic [31:0] hrdata;
	logic hready;
	logic hresp;
	logic nmi = 1'b0;
	logic [4:0] line_n = 5'h1F;
	logic [EIPC_NINT-1:0] ireq = '0;
	logic ack;
	logic [7:0] ack_vec;
	logic req;
	logic is_nmi;
	logic lvl;
	logic wake;
	logic [7:0] vec;
	logic core_en = 1'b0;
	logic [3:0] core_dly = 4'h3;
	logic [31:0] rd;
	int n_errors = 0;
	int num_checks = 0;
	logic [7:0] offs [6] = '{EIPC_OFF_PRI_A, EIPC_OFF_PRI_B, EIPC_OFF_SENSE,
		EIPC_OFF_ENABLE, EIPC_OFF_FLAGS, EIPC_OFF_SYSCTL};
	int bits [5] = '{10, 13, 16, 20, 7};
	logic [7:0] vexp [5] = '{8'h24, 8'h28, 8'h34, EIPC_VEC_ADC, 8'h20};
	logic [7:0] pb [5] = '{8'h80, 8'h40, 8'h08, 8'h02, 8'h00};
	logic [7:0] pa [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01};

	always #50 clk = ~clk;

	eipc_ctrl u_dut (.core_clk_in(clk), .srst_in(srst), .hw_standby_in(stby),
		.hsel_in(1'b1), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
		.hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
		.hreadyout_out(hready), .hresp_out(hresp), .nmi_pin_in(nmi), .line_n_in(line_n),
		.int_req_in(ireq), .cpu_ack_in(ack), .cpu_ack_vec_in(ack_vec), .irq_req_out(req),
		.irq_nmi_out(is_nmi), .irq_level_out(lvl), .irq_vec_out(vec), .wake_out(wake));

	eipc_core_model u_core (.clk_in(clk), .srst_in(srst), .en_in(core_en),
		.delay_in(core_dly), .irq_req_in(req), .irq_vec_in(vec), .ack_out(ack),
		.ack_vec_out(ack_vec));

	task automatic wrap_up;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
		end
	endtask

	// entered right after a rising edge; read data is taken at the closing edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		haddr <= {24'h000000, a};
		htrans <= EIPC_HTRANS_NONSEQ;
		hwrite <= wr;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		rd = hrdata;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h00000000);
		chk(rd, exp);
		chk(hresp, 1'b0);
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk);
	endtask

	initial begin
		step(5000);
		n_errors++;
		wrap_up();
	end

	initial begin
		step(4);
		srst <= 1'b0;
		foreach (offs[i]) rdchk(offs[i], (i == 5) ? 32'h0000000B : 32'h0);
		for (int i = 1; i < 4; i++) bus(1'b1, offs[i], 32'h000000FF);
		for (int i = 1; i < 4; i++) rdchk(offs[i], 32'h000000FF);
		bus(1'b1, EIPC_OFF_FLAGS, 32'h000000FF);
		rdchk(EIPC_OFF_FLAGS, 32'h0);
		bus(1'b1, 8'h1C, 32'h000000FF);
		rdchk(8'h1C, 32'h0);
		for (int i = 1; i < 4; i++) bus(1'b1, offs[i], 32'h0);
		// level sensing on each line in turn
		bus(1'b1, EIPC_OFF_ENABLE, 32'h0000001F);
		for (int n = 0; n < 5; n++) begin
			line_n <= ~(5'h01 << n);
			step(6);
			chk({req, lvl, vec}, {1'b1, 1'b0, 8'h0C + n[7:0]});
			chk(wake, n < 3);
			line_n <= 5'h1F;
			step(4);
			rdchk(EIPC_OFF_FLAGS, 32'h1 << n);
			bus(1'b1, EIPC_OFF_FLAGS, 32'h0);
			rdchk(EIPC_OFF_FLAGS, 32'h0);
		end
		// disabled line still flags; a write of 0 without a prior read is ignored
		bus(1'b1, EIPC_OFF_ENABLE, 32'h0000001E);
		line_n <= 5'h1E;
		step(6);
		line_n <= 5'h1F;
		chk(req, 1'b0);
		bus(1'b1, EIPC_OFF_FLAGS, 32'h0);
		rdchk(EIPC_OFF_FLAGS, 32'h1);
		bus(1'b1, EIPC_OFF_FLAGS, 32'h0);
		// level line handled by the core while the pin stays low
		bus(1'b1, EIPC_OFF_ENABLE, 32'h1);
		line_n <= 5'h1E;
		core_en <= 1'b1;
		step(10);
		chk(req, 1'b1);
		line_n <= 5'h1F;
		step(10);
		chk(req, 1'b0);
		// edge line: one flag per falling edge, cleared by handling
		core_en <= 1'b0;
		bus(1'b1, EIPC_OFF_SENSE, 32'h1);
		line_n <= 5'h1E;
		step(6);
		chk({req, vec}, {1'b1, 8'h0C});
		core_en <= 1'b1;
		step(10);
		chk(req, 1'b0);
		rdchk(EIPC_OFF_FLAGS, 32'h0);
		core_en <= 1'b0;
		line_n <= 5'h1F;
		// line 4 raised to level 1 overtakes line 0
		bus(1'b1, EIPC_OFF_SENSE, 32'h0);
		bus(1'b1, EIPC_OFF_ENABLE, 32'h0000001F);
		bus(1'b1, EIPC_OFF_PRI_A, 32'h00000010);
		line_n <= 5'h0E;
		step(6);
		chk({lvl, vec}, {1'b1, 8'h10});
		line_n <= 5'h1F;
		rdchk(EIPC_OFF_FLAGS, 32'h00000011);
		bus(1'b1, EIPC_OFF_FLAGS, 32'h0);
		// module levels against the watchdog request at level 0
		foreach (bits[i]) begin
			ireq <= (21'h1 << bits[i]) | 21'h1;
			bus(1'b1, EIPC_OFF_PRI_B, 32'h35);
			bus(1'b1, EIPC_OFF_PRI_A, 32'h0);
			step(3);
			chk({lvl, vec}, {1'b0, 8'h14});
			bus(1'b1, EIPC_OFF_PRI_B, {24'h0, pb[i]});
			bus(1'b1, EIPC_OFF_PRI_A, {24'h0, pa[i]});
			step(3);
			chk({lvl, vec}, {1'b1, vexp[i]});
		end
		// nonmaskable pin, falling edge by default
		nmi <= 1'b1;
		step(6);
		chk(is_nmi, 1'b0);
		nmi <= 1'b0;
		step(6);
		chk({req, is_nmi, vec}, {1'b1, 1'b1, EIPC_VEC_NMI});
		rdchk(EIPC_OFF_STATUS, 32'h00000307);
		core_en <= 1'b1;
		step(8);
		chk(is_nmi, 1'b0);
		core_en <= 1'b0;
		bus(1'b1, EIPC_OFF_SYSCTL, 32'h0000000F);
		nmi <= 1'b1;
		step(6);
		chk({is_nmi, vec}, {1'b1, EIPC_VEC_NMI});
		ireq <= '0;
		// hardware standby clears the registers again
		bus(1'b1, EIPC_OFF_ENABLE, 32'h000000FF);
		stby <= 1'b1;
		step(2);
		stby <= 1'b0;
		rdchk(EIPC_OFF_ENABLE, 32'h0);
		rdchk(EIPC_OFF_SYSCTL, 32'h0000000B);
		chk(is_nmi, 1'b0);
		wrap_up();
	end
endmodule // eipc_ctrl_tb_top
